// >>> rtl/sbg_top.sv
// Notes on behaviour
// RULE1: on disable, brake release stays active for the off-delay, then drops.
// RULE2: during the off-delay, speed below zero-speed threshold engages the brake at once.
// RULE3: when the off-delay expires the brake engages whatever the speed.
// RULE4: disable by non-exempt fault or emergency stop treats negative delay as zero.
// RULE5: command pulse rate is input rate times numerator over denominator.
// RULE6: primary numerator is 32-bit, accepting 1 to 2^29-1.
// RULE7: denominator is 32-bit, accepting 1 to 2^31-1.
// RULE8: software keeps the ratio strictly between 1/50 and 25600.
// RULE9: three extra numerators, any selectable as the ratio numerator.
// RULE10: pulse-train mode: primary numerator writable only while enabled.
// RULE11: internal-register mode: primary numerator writable only while disabled.
// RULE12: denominator writes refused while enabled in both modes.
// RULE13: encoder output pulses per revolution 20 to 320000, default 2500.
// RULE14: encoder-output fault on encoder error, overspeed or output frequency excess.
// RULE15: off-delay timed in milliseconds from the moment disable takes effect.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module sbg_top
  import sbg_pkg::*;
#(
  parameter int MS_TICKS      = MS_CYCLES,
  parameter int ENC_COUNTS_REV = 160000
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // drive state inputs, same clock
  input  wire logic [15:0] motor_speed,
  input  wire logic        fault_active,
  input  wire logic [7:0]  fault_code,
  // pins
  input  wire logic        emergency_stop_input,
  input  wire logic        encoder_error_in,
  input  wire logic        cmd_pulse_in,
  input  wire logic        enc_count_in,
  // outputs
  output logic             brake_release_output,
  output logic             power_stage_enable,
  output logic             position_cmd_pulse,
  output logic             encoder_out_pulse,
  output logic             encoder_output_fault,
  output logic             irq
);
  // pin synchronisers
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] pins_v;
  logic       cmd_prev_q;
  logic       enc_prev_q;
  assign pins_v = {enc_count_in, cmd_pulse_in, encoder_error_in, emergency_stop_input};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q    <= 4'h0;
      sync2_q    <= 4'h0;
      cmd_prev_q <= 1'b0;
      enc_prev_q <= 1'b0;
    end else begin
      sync1_q    <= pins_v;
      sync2_q    <= sync1_q;
      cmd_prev_q <= sync2_q[2];
      enc_prev_q <= sync2_q[3];
    end
  end

  logic emergency_stop_input_s;
  logic enc_err_s;
  assign emergency_stop_input_s    = sync2_q[0];
  assign enc_err_s = sync2_q[1];

  // registers
  logic [31:0] num1_q, num1_d, den_q, den_d, ppr_q, ppr_d;
  logic [31:0] numx_q [3];
  logic [31:0] numx_d [3];
  logic [3:0]  ctrl_q, ctrl_d;
  logic [15:0] off_delay_q, off_delay_d, zero_spd_q, zero_spd_d, spd_lim_q, spd_lim_d;
  logic [INT_BITS-1:0] ist_q, ist_d, imask_q, imask_d;
  logic        dp_q, dp_d, wait_q, wait_d, dpw_q, dpw_d;
  logic [9:0]  dpidx_q, dpidx_d;
  logic [31:0] rdata_q, rdata_d;
  logic        refuse_v;
  logic        fault_q;
  logic        enabled_v;
  sbg_brake_e  st_q, st_d;

  // brake timing
  logic [31:0] tick_q, tick_d;
  logic [15:0] ms_q, ms_d;
  logic        neg_zero_v, disable_v, brake_eng_ev;
  logic [15:0] mag_v;

  assign enabled_v  = (st_q == ST_ON);
  assign disable_v  = !ctrl_q[CTRL_SERVO_ON] || fault_active || emergency_stop_input_s;
  assign neg_zero_v = emergency_stop_input_s || (fault_active && fault_code != EXEMPT_FAULT_CODE); // RULE4
  assign mag_v      = off_delay_q[15] ? 16'(-off_delay_q) : off_delay_q;

  always_comb begin
    st_d         = st_q;
    tick_d       = tick_q;
    ms_d         = ms_q;
    brake_eng_ev = 1'b0;
    if (st_q != ST_ON && st_q != ST_OFF) begin
      if (tick_q >= 32'(MS_TICKS - 1)) begin // RULE15
        tick_d = 32'h0;
        ms_d   = ms_q + 16'h1;
      end else begin
        tick_d = tick_q + 32'h1;
      end
    end
    case (st_q)
      ST_ON: begin
        if (disable_v) begin
          tick_d = 32'h0;
          ms_d   = 16'h0;
          if (off_delay_q == 16'h0 || (off_delay_q[15] && neg_zero_v)) begin // RULE4
            st_d         = ST_OFF;
            brake_eng_ev = 1'b1;
          end else if (off_delay_q[15]) begin
            st_d         = ST_HOLD;
            brake_eng_ev = 1'b1;
          end else begin
            st_d = ST_DELAY; // RULE1
          end
        end
      end
      ST_DELAY: begin
        if (ms_q >= off_delay_q) begin
          st_d         = ST_OFF; // RULE1 RULE3
          brake_eng_ev = 1'b1;
        end else if (motor_speed < zero_spd_q) begin
          st_d         = ST_OFF; // RULE2
          brake_eng_ev = 1'b1;
        end
      end
      ST_HOLD: begin
        if (ms_q >= mag_v || neg_zero_v) begin
          st_d = ST_OFF;
        end
      end
      ST_OFF: begin
        if (!disable_v) begin
          st_d = ST_ON;
        end
      end
      default: st_d = ST_OFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q   <= ST_OFF;
      tick_q <= 32'h0;
      ms_q   <= 16'h0;
    end else begin
      st_q   <= st_d;
      tick_q <= tick_d;
      ms_q   <= ms_d;
    end
  end

  assign brake_release_output = (st_q == ST_ON) || (st_q == ST_DELAY);
  assign power_stage_enable   = (st_q != ST_OFF);

  // gear and encoder output scalers
  sbg_scale_if gear_if ();
  sbg_scale_if enc_if ();

  always_comb begin
    case (ctrl_q[CTRL_GSEL_LO +: 2]) // RULE9
      2'd1:    gear_if.num = numx_q[0];
      2'd2:    gear_if.num = numx_q[1];
      2'd3:    gear_if.num = numx_q[2];
      default: gear_if.num = num1_q;
    endcase
  end
  assign gear_if.den      = den_q;
  assign gear_if.pulse_in = sync2_q[2] && !cmd_prev_q && enabled_v; // RULE5
  assign enc_if.num       = ppr_q; // RULE13
  assign enc_if.den       = 32'(ENC_COUNTS_REV);
  assign enc_if.pulse_in  = sync2_q[3] && !enc_prev_q;

  sbg_scaler u_gear (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sc      (gear_if.scaler)
  );

  sbg_scaler u_enc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sc      (enc_if.scaler)
  );

  assign position_cmd_pulse = gear_if.pulse_out;
  assign encoder_out_pulse  = enc_if.pulse_out;

  // encoder output fault
  logic [47:0] freq_prod_v;
  logic        fault_d;
  assign freq_prod_v = {32'h0, motor_speed} * {16'h0, ppr_q};
  assign fault_d     = enc_err_s || (motor_speed > spd_lim_q) || (freq_prod_v > ENC_FREQ_PRODUCT); // RULE14

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end
  assign encoder_output_fault = fault_q;

  // bus slave: one wait cycle per transfer
  logic        acc_v;
  logic        wr_v;
  logic [31:0] rd_v;
  assign acc_v = hsel && hready && htrans[1];
  assign wr_v  = dp_q && wait_q && dpw_q;

  always_comb begin
    case (dpidx_q)
      IDX_GEAR_NUM1:   rd_v = num1_q;
      IDX_GEAR_DEN:    rd_v = den_q;
      IDX_ENC_PPR:     rd_v = ppr_q;
      IDX_CTRL:        rd_v = {28'h0, ctrl_q};
      IDX_OFF_DELAY:   rd_v = {16'h0, off_delay_q};
      IDX_ZERO_SPEED:  rd_v = {16'h0, zero_spd_q};
      IDX_SPEED_LIMIT: rd_v = {16'h0, spd_lim_q};
      IDX_GEAR_NUM2:   rd_v = numx_q[0];
      IDX_GEAR_NUM3:   rd_v = numx_q[1];
      IDX_GEAR_NUM4:   rd_v = numx_q[2];
      IDX_STATUS:      rd_v = {27'h0, st_q, power_stage_enable, fault_q, brake_release_output};
      IDX_INT_STATUS:  rd_v = {29'h0, ist_q};
      IDX_INT_MASK:    rd_v = {29'h0, imask_q};
      default:         rd_v = 32'h0;
    endcase
  end

  always_comb begin
    dp_d        = dp_q;
    wait_d      = 1'b0;
    dpw_d       = dpw_q;
    dpidx_d     = dpidx_q;
    rdata_d     = rdata_q;
    num1_d      = num1_q;
    den_d       = den_q;
    ppr_d       = ppr_q;
    numx_d      = numx_q;
    ctrl_d      = ctrl_q;
    off_delay_d = off_delay_q;
    zero_spd_d  = zero_spd_q;
    spd_lim_d   = spd_lim_q;
    imask_d     = imask_q;
    ist_d       = ist_q;
    refuse_v    = 1'b0;
    if (dp_q && wait_q) begin
      dp_d = 1'b0;
    end else if (dp_q) begin
      wait_d = 1'b1;
      if (!dpw_q) begin
        rdata_d = rd_v;
        if (dpidx_q == IDX_INT_STATUS) begin
          ist_d = '0;
        end
      end
    end
    if (acc_v && !(dp_q && !wait_q)) begin
      dp_d    = 1'b1;
      dpw_d   = hwrite;
      dpidx_d = haddr[11:2];
    end
    if (wr_v) begin
      case (dpidx_q)
        IDX_GEAR_NUM1: begin
          if (hwdata == 32'h0 || hwdata > NUM1_MAX) begin // RULE6
            refuse_v = 1'b1;
          end else if (ctrl_q[CTRL_MODE_PR] ? enabled_v : !enabled_v) begin // RULE10 RULE11
            refuse_v = 1'b1;
          end else begin
            num1_d = hwdata;
          end
        end
        IDX_GEAR_DEN: begin
          if (hwdata == 32'h0 || hwdata > DEN_MAX || enabled_v) begin // RULE7 RULE12
            refuse_v = 1'b1;
          end else begin
            den_d = hwdata;
          end
        end
        IDX_ENC_PPR: begin
          if (hwdata < PPR_MIN || hwdata > PPR_MAX) begin // RULE13
            refuse_v = 1'b1;
          end else begin
            ppr_d = hwdata;
          end
        end
        IDX_CTRL:        ctrl_d      = hwdata[3:0];
        IDX_OFF_DELAY:   off_delay_d = hwdata[15:0];
        IDX_ZERO_SPEED:  zero_spd_d  = hwdata[15:0];
        IDX_SPEED_LIMIT: spd_lim_d   = hwdata[15:0];
        IDX_GEAR_NUM2:   numx_d[0]   = hwdata;
        IDX_GEAR_NUM3:   numx_d[1]   = hwdata;
        IDX_GEAR_NUM4:   numx_d[2]   = hwdata;
        IDX_INT_MASK:    imask_d     = hwdata[INT_BITS-1:0];
        default:         refuse_v    = 1'b0;
      endcase
    end
    // set wins over read-clear
    if (fault_d && !fault_q) ist_d[INT_ENC_FAULT] = 1'b1;
    if (refuse_v)            ist_d[INT_WR_REFUSE] = 1'b1;
    if (brake_eng_ev)        ist_d[INT_BRAKE_ENG] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q        <= 1'b0;
      wait_q      <= 1'b0;
      dpw_q       <= 1'b0;
      dpidx_q     <= 10'h0;
      rdata_q     <= 32'h0;
      num1_q      <= RST_GEAR_NUM1;
      den_q       <= RST_GEAR_DEN;
      ppr_q       <= RST_ENC_PPR;
      numx_q      <= '{RST_GEAR_NUMX, RST_GEAR_NUMX, RST_GEAR_NUMX};
      ctrl_q      <= 4'h0;
      off_delay_q <= RST_OFF_DELAY;
      zero_spd_q  <= RST_ZERO_SPEED;
      spd_lim_q   <= RST_SPEED_LIMIT;
      ist_q       <= '0;
      imask_q     <= '0;
    end else begin
      dp_q        <= dp_d;
      wait_q      <= wait_d;
      dpw_q       <= dpw_d;
      dpidx_q     <= dpidx_d;
      rdata_q     <= rdata_d;
      num1_q      <= num1_d;
      den_q       <= den_d;
      ppr_q       <= ppr_d;
      numx_q      <= numx_d;
      ctrl_q      <= ctrl_d;
      off_delay_q <= off_delay_d;
      zero_spd_q  <= zero_spd_d;
      spd_lim_q   <= spd_lim_d;
      ist_q       <= ist_d;
      imask_q     <= imask_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = !(dp_q && !wait_q);
  assign hresp     = 1'b0;
  assign irq       = |(ist_q & imask_q);
endmodule : sbg_top
`default_nettype wire

// >>> rtl/sbg_pkg.sv
package sbg_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_GEAR_NUM1    = 10'h158;
  localparam logic [9:0]  IDX_GEAR_DEN     = 10'h15A;
  localparam logic [9:0]  IDX_ENC_PPR      = 10'h15C;
  localparam logic [9:0]  IDX_CTRL         = 10'h170;
  localparam logic [9:0]  IDX_OFF_DELAY    = 10'h171;
  localparam logic [9:0]  IDX_ZERO_SPEED   = 10'h172;
  localparam logic [9:0]  IDX_SPEED_LIMIT  = 10'h173;
  localparam logic [9:0]  IDX_GEAR_NUM2    = 10'h174;
  localparam logic [9:0]  IDX_GEAR_NUM3    = 10'h175;
  localparam logic [9:0]  IDX_GEAR_NUM4    = 10'h176;
  localparam logic [9:0]  IDX_STATUS       = 10'h177;
  localparam logic [9:0]  IDX_INT_STATUS   = 10'h178;
  localparam logic [9:0]  IDX_INT_MASK     = 10'h179;
  // reset values
  localparam logic [31:0] RST_GEAR_NUM1    = 32'h0000_0080;
  localparam logic [31:0] RST_GEAR_DEN     = 32'h0000_000A;
  localparam logic [31:0] RST_ENC_PPR      = 32'h0000_09C4;
  localparam logic [31:0] RST_GEAR_NUMX    = 32'h0000_0080;
  localparam logic [15:0] RST_OFF_DELAY    = 16'h0000;
  localparam logic [15:0] RST_ZERO_SPEED   = 16'h000A;
  localparam logic [15:0] RST_SPEED_LIMIT  = 16'h1770;
  // accepted ranges
  localparam logic [31:0] NUM1_MAX         = 32'h1FFF_FFFF;
  localparam logic [31:0] DEN_MAX          = 32'h7FFF_FFFF;
  localparam logic [31:0] PPR_MIN          = 32'h0000_0014;
  localparam logic [31:0] PPR_MAX          = 32'h0004_E200;
  // speed/60 * ppr * 4 > 19.8e6  <=>  speed * ppr > 297e6
  localparam logic [47:0] ENC_FREQ_PRODUCT = 48'h0000_11B3_DC40;
  // field positions
  localparam int CTRL_SERVO_ON = 0;
  localparam int CTRL_MODE_PR  = 1;
  localparam int CTRL_GSEL_LO  = 2;
  localparam int INT_ENC_FAULT = 0;
  localparam int INT_WR_REFUSE = 1;
  localparam int INT_BRAKE_ENG = 2;
  localparam int INT_BITS      = 3;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam logic [7:0] EXEMPT_FAULT_CODE = 8'h22;
  typedef enum logic [1:0] {
    ST_ON    = 2'b00,
    ST_DELAY = 2'b01,
    ST_HOLD  = 2'b10,
    ST_OFF   = 2'b11
  } sbg_brake_e;
endpackage : sbg_pkg

// >>> rtl/sbg_scale_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sbg_scale_if;
  logic [31:0] num;
  logic [31:0] den;
  logic        pulse_in;
  logic        pulse_out;
  modport owner  (output num, output den, output pulse_in, input pulse_out);
  modport scaler (input num, input den, input pulse_in, output pulse_out);
endinterface : sbg_scale_if
`default_nettype wire

// >>> rtl/sbg_scaler.sv
`timescale 1ns/1ps
`default_nettype none
module sbg_scaler
  import sbg_pkg::*;
(
  // clock and reset
  input wire logic  hclk,
  input wire logic  hresetn,
  // scaling port
  sbg_scale_if.scaler sc
);
  logic [63:0] acc_q;
  logic [63:0] acc_d;
  logic        out_q;
  logic        out_d;
  logic [63:0] add_v;
  logic [63:0] sub_v;

  // each input pulse adds num; one output pulse per den accumulated
  always_comb begin
    add_v = sc.pulse_in ? {32'h0000_0000, sc.num} : 64'h0;
    out_d = (acc_q >= {32'h0000_0000, sc.den}) && (sc.den != 32'h0);
    sub_v = out_d ? {32'h0000_0000, sc.den} : 64'h0;
    acc_d = acc_q + add_v - sub_v;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 64'h0;
      out_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      out_q <= out_d;
    end
  end

  assign sc.pulse_out = out_q;
endmodule : sbg_scaler
`default_nettype wire

// >>> sim/sbg_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sbg_top_asserts (
  // bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // drive
  input wire logic        fault_active,
  input wire logic        emergency_stop_input,
  input wire logic        encoder_error_in,
  input wire logic        brake_release_output,
  input wire logic        power_stage_enable,
  input wire logic        encoder_output_fault
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay;
    !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_wait;
    hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("wait cycle wrong");
  property p_rdata_hold;
    $past(hreadyout) |-> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved");
  property p_brake_power;
    brake_release_output |-> power_stage_enable;
  endproperty
  a_brake_power: assert property (p_brake_power) else $error("brake open unpowered");
  property p_rise_together;
    $rose(brake_release_output) |-> $rose(power_stage_enable);
  endproperty
  a_rise_together: assert property (p_rise_together) else $error("brake opened late");
  property p_no_fault_rise;
    $rose(power_stage_enable) |-> !$past(fault_active);
  endproperty
  a_no_fault_rise: assert property (p_no_fault_rise) else $error("enabled under fault");
  property p_no_estop_rise;
    emergency_stop_input [*4] |=> !$rose(power_stage_enable);
  endproperty
  a_no_estop_rise: assert property (p_no_estop_rise) else $error("enabled under stop");
  property p_enc_fault;
    encoder_error_in [*5] |-> encoder_output_fault;
  endproperty
  a_enc_fault: assert property (p_enc_fault) else $error("no output fault");
endmodule : sbg_top_asserts
bind sbg_top sbg_top_asserts u_chk (.hclk, .hresetn, .hsel, .htrans, .hready, .hrdata, .hreadyout, .hresp,
  .fault_active, .emergency_stop_input, .encoder_error_in, .brake_release_output, .power_stage_enable,
  .encoder_output_fault);
`default_nettype wire

// >>> sim/sbg_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbg_motor_model (
  // clock
  input wire logic        hclk,
  // motor and encoder
  output var logic [15:0] motor_speed,
  output var logic        encoder_error_in,
  output var logic        enc_count_in
);
  initial begin
    motor_speed = 16'h0000;
    encoder_error_in = 1'b0;
    enc_count_in = 1'b0;
  end
  task automatic set(input logic [15:0] s, input logic e);
    motor_speed <= s;
    encoder_error_in <= e;
    @(posedge hclk);
  endtask : set
  // counts held four cycles each so the sync sees them
  task automatic spin(input int n);
    repeat (n) begin
      enc_count_in <= 1'b1;
      repeat (4) @(posedge hclk);
      enc_count_in <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    repeat (12) @(posedge hclk);
  endtask : spin
endmodule : sbg_motor_model
`default_nettype wire

// >>> sim/servo_brake_gear_encoder_out_bench.sv
`timescale 1ns/1ps
`default_nettype none
module servo_brake_gear_encoder_out_bench;
  import sbg_pkg::*;
  localparam int MST = 10;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fault_active, emergency_stop_input;
  logic        cmd_pulse_in, brake_release_output, power_stage_enable, position_cmd_pulse;
  logic        encoder_out_pulse, encoder_output_fault, irq;
  wire logic   encoder_error_in, enc_count_in;
  wire logic [15:0] motor_speed;
  logic [1:0]  htrans;
  logic [7:0]  fault_code;
  logic [31:0] haddr, hwdata, hrdata;
  int          errors, checked, pcnt, ecnt, c;
  int          gn [4] = '{6, 2, 4, 8};
  logic [31:0] tv [12] = '{32'h0, NUM1_MAX + 32'h1, NUM1_MAX, 32'h1, 32'h0, DEN_MAX + 32'h1, DEN_MAX, 32'h1,
                           PPR_MIN - 32'h1, PPR_MAX + 32'h1, PPR_MAX, PPR_MIN};
  logic [31:0] te [12] = '{RST_GEAR_NUM1, RST_GEAR_NUM1, NUM1_MAX, 32'h1, RST_GEAR_DEN, RST_GEAR_DEN, DEN_MAX,
                           32'h1, RST_ENC_PPR, RST_ENC_PPR, PPR_MAX, PPR_MIN};
  logic [15:0] fs [5] = '{16'h0000, 16'h1771, 16'h1770, 16'h03A0, 16'h03A1};
  logic [4:0]  fx = 5'h13;
  sbg_top #(.MS_TICKS(MST), .ENC_COUNTS_REV(4)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .motor_speed, .fault_active,
    .fault_code, .emergency_stop_input, .encoder_error_in, .cmd_pulse_in, .enc_count_in, .brake_release_output,
    .power_stage_enable, .position_cmd_pulse, .encoder_out_pulse, .encoder_output_fault, .irq);
  sbg_motor_model u_motor (.hclk, .motor_speed, .encoder_error_in, .enc_count_in);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (position_cmd_pulse === 1'b1) pcnt++;
    if (encoder_out_pulse === 1'b1) ecnt++;
  end
  task automatic give_verdict;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // wait for the level, bounded
  task automatic wait_for(input bit pwr, input logic lvl, output int k);
    k = 0;
    while ((pwr ? power_stage_enable : brake_release_output) !== lvl && k < 300) begin
      @(posedge hclk);
      k++;
    end
    if (k >= 300) begin
      errors++;
      give_verdict;
    end
  endtask : wait_for
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      give_verdict;
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h00000, i, 2'h0};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
  endtask : bus
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask : wr
  task automatic rdc(input logic [9:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk(hrdata, e);
  endtask : rdc
  task automatic svon(input logic [31:0] v);
    int k;
    wr(IDX_CTRL, v);
    wait_for(1'b1, 1'b1, k);
  endtask : svon
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fault_active = 1'b0;
    fault_code = 8'h00;
    emergency_stop_input = 1'b0;
    cmd_pulse_in = 1'b0;
    errors = 0;
    checked = 0;
    pcnt = 0;
    ecnt = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(IDX_GEAR_NUM1, RST_GEAR_NUM1);
    rdc(IDX_GEAR_DEN, RST_GEAR_DEN);
    rdc(IDX_ENC_PPR, RST_ENC_PPR);
    wr(10'h3F0, 32'h1234_5678);
    rdc(10'h3F0, 32'h0);
    wr(IDX_CTRL, 32'h2);
    for (int t = 0; t < 12; t++) begin
      wr(IDX_GEAR_NUM1 + 10'(t / 4 * 2), tv[t]);
      rdc(IDX_GEAR_NUM1 + 10'(t / 4 * 2), te[t]);
    end
    rdc(IDX_INT_STATUS, 32'h2);
    rdc(IDX_INT_STATUS, 32'h0);
    $display("test ranges done");
    svon(32'h3);
    rdc(IDX_STATUS, 32'h5);
    wr(IDX_GEAR_NUM1, 32'h5);
    rdc(IDX_GEAR_NUM1, 32'h1);
    wr(IDX_GEAR_DEN, 32'h5);
    rdc(IDX_GEAR_DEN, 32'h1);
    wr(IDX_CTRL, 32'h1);
    wr(IDX_GEAR_NUM1, 32'h6);
    rdc(IDX_GEAR_NUM1, 32'h6);
    wr(IDX_GEAR_DEN, 32'h5);
    rdc(IDX_GEAR_DEN, 32'h1);
    wr(IDX_CTRL, 32'h0);
    wait_for(1'b1, 1'b0, c);
    wr(IDX_GEAR_NUM1, 32'h7);
    rdc(IDX_GEAR_NUM1, 32'h6);
    wr(IDX_GEAR_DEN, 32'h2);
    rdc(IDX_GEAR_DEN, 32'h2);
    $display("test write locks done");
    for (int g = 1; g < 4; g++) wr(IDX_GEAR_NUM2 + 10'(g - 1), 32'(gn[g]));
    svon(32'h1);
    for (int g = 0; g < 4; g++) begin
      wr(IDX_CTRL, 32'(g * 4 + 1));
      pcnt = 0;
      repeat (4) begin
        cmd_pulse_in <= 1'b1;
        repeat (4) @(posedge hclk);
        cmd_pulse_in <= 1'b0;
        repeat (4) @(posedge hclk);
      end
      repeat (12) @(posedge hclk);
      chk(32'(pcnt), 32'(2 * gn[g]));
    end
    ecnt = 0;
    u_motor.spin(4);
    chk(32'(ecnt), PPR_MIN);
    $display("test gear done");
    bus(1'b0, IDX_INT_STATUS, 32'h0);
    wr(IDX_OFF_DELAY, 32'h3);
    u_motor.set(16'h0064, 1'b0);
    wr(IDX_CTRL, 32'h0);
    rdc(IDX_STATUS, 32'h0000_000D);
    wait_for(1'b0, 1'b0, c);
    chk(32'(c >= 3 * MST - 3 && c <= 3 * MST + 4), 32'h1);
    chk(32'(power_stage_enable), 32'h0);
    rdc(IDX_INT_STATUS, 32'h4);
    wr(IDX_ZERO_SPEED, 32'h0000_0040);
    u_motor.set(16'h0030, 1'b0);
    svon(32'h1);
    wr(IDX_CTRL, 32'h0);
    wait_for(1'b0, 1'b0, c);
    chk(32'(c <= 3), 32'h1);
    $display("test delay done");
    wr(IDX_OFF_DELAY, 32'h0000_FFFE);
    u_motor.set(16'h0064, 1'b0);
    for (int k = 0; k < 4; k++) begin
      svon(32'h1);
      if (k == 0) begin
        wr(IDX_CTRL, 32'h0);
      end else if (k == 1) begin
        emergency_stop_input <= 1'b1;
      end else begin
        fault_active <= 1'b1;
        fault_code <= (k == 2) ? EXEMPT_FAULT_CODE : 8'h11;
      end
      wait_for(1'b0, 1'b0, c);
      chk(32'(c <= 4), 32'h1);
      rdc(IDX_STATUS, (k == 0 || k == 2) ? 32'h0000_0014 : 32'h0000_0018);
      wait_for(1'b1, 1'b0, c);
      chk(32'(c >= MST), 32'(k == 0 || k == 2));
      emergency_stop_input <= 1'b0;
      fault_active <= 1'b0;
      @(posedge hclk);
    end
    $display("test negative delay done");
    bus(1'b0, IDX_INT_STATUS, 32'h0);
    for (int f = 0; f < 5; f++) begin
      wr(IDX_ENC_PPR, f > 2 ? PPR_MAX : PPR_MIN);
      u_motor.set(fs[f], f == 0);
      repeat (6) @(posedge hclk);
      chk(32'(encoder_output_fault), 32'(fx[f]));
    end
    u_motor.set(16'h0000, 1'b0);
    chk(32'(irq), 32'h0);
    wr(IDX_INT_MASK, 32'h1);
    @(posedge hclk);
    chk(32'(irq), 32'h1);
    rdc(IDX_INT_STATUS, 32'h1);
    @(posedge hclk);
    chk(32'(irq), 32'h0);
    $display("test fault done");
    give_verdict;
  end
endmodule : servo_brake_gear_encoder_out_bench
`default_nettype wire
